//--- interrupt_pin_routing.v
// The implementer's own choice: the APB slave port.
`include "irq_routing_defines.vh"

module interrupt_pin_routing
(
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Request sources, same clock domain
    input wire motion_sample_request,
    input wire [1:0] fifo_flags,
    // Interrupt pins
    output wire irq_pin_a_out,
    output wire irq_pin_a_oe,
    output wire irq_pin_b_out,
    output wire irq_pin_b_oe,
    // Summary interrupt
    output wire irq
);

    // Requests arrive as levels from flag logic on this clock, so they
    // are used without synchronisers. Routing is combinational and each
    // pin driver registers its pad, giving one cycle from a request or
    // configuration change to the pad. Status bits record rising edges
    // of the routed requests per physical pin, so a swap moves which
    // status bit a source sets. Trade-off: a swap or merge written while
    // a request stands can itself create an edge and set status.

    // Pin drive and polarity bits; reserved bits always zero
    reg [7:0] pin_ctrl_q;
    // Request swap control; only the swap bit is kept
    reg [7:0] swap_ctrl_q;
    // FIFO enables and merge control
    reg [7:0] fifo_ctrl_q;
    // Sticky request-edge status, one bit per pin
    reg [`IRQ_BITS-1:0] status_q;
    // Next status value
    reg [`IRQ_BITS-1:0] status_d;
    // Interrupt mask, same layout as status
    reg [`IRQ_BITS-1:0] mask_q;
    // Previous routed requests for edge detection
    reg [1:0] routed_prev_q;

    // Register hits, one per decoded word
    wire hit_pin_ctrl;
    wire hit_swap_ctrl;
    wire hit_fifo_ctrl;
    wire hit_status;
    wire hit_mask;
    wire hit_flags;
    // Any known register addressed
    wire hit_any;

    // Bus strobes
    wire wr_en;
    wire rd_en;
    // Gated FIFO request before merging
    wire fifo_request;
    // Motion line with the FIFO folded in on merge
    wire merged_request;
    // Separate FIFO line, silent while merged
    wire fifo_line;
    // Swap control bit
    wire swap;
    // Merge control bit
    wire merge;
    // Routed requests per physical pin
    wire req_a;
    wire req_b;
    // Rising edges of the routed requests
    wire [1:0] rise;

    // Byte address of a register index: one aligned word per index
    function [7:0] word_addr;
        input [7:0] idx;
        begin
            word_addr = {idx[`IDX_MSB:0], 2'b00};
        end
    endfunction

    // Full-width match; a misaligned byte address hits nothing
    function addr_hit;
        input [7:0] addr;
        input [7:0] idx;
        begin
            addr_hit = (addr == word_addr(idx));
        end
    endfunction

    // Address decode; shared by write, read and error paths
    assign hit_pin_ctrl = addr_hit(paddr, `IDX_PIN_CTRL);
    assign hit_swap_ctrl = addr_hit(paddr, `IDX_SWAP_CTRL);
    assign hit_fifo_ctrl = addr_hit(paddr, `IDX_FIFO_CTRL);
    assign hit_status = addr_hit(paddr, `IDX_IRQ_STATUS);
    assign hit_mask = addr_hit(paddr, `IDX_IRQ_MASK);
    assign hit_flags = addr_hit(paddr, `IDX_FIFO_FLAGS);
    assign hit_any = hit_pin_ctrl | hit_swap_ctrl | hit_fifo_ctrl |
        hit_status | hit_mask | hit_flags;

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    // Writes land at the end of the access phase
    assign wr_en = psel & penable & pwrite & clk_en;
    // Reads are captured in the setup cycle so prdata is a flop
    assign rd_en = psel & ~penable & ~pwrite;

    // Control bits pulled out once for readability
    assign swap = swap_ctrl_q[`REQUEST_SWAP_BIT];
    assign merge = fifo_ctrl_q[`MERGE_REQUESTS_BIT];

    // FIFO request only from enabled FIFO flags
    assign fifo_request =
        (fifo_flags[`FIFO_FLAG_FULL] & fifo_ctrl_q[`FIFO_FULL_EN_BIT]) |
        (fifo_flags[`FIFO_FLAG_THRESH] &
         fifo_ctrl_q[`FIFO_THRESH_EN_BIT]);

    // Merge folds FIFO into the motion line
    assign merged_request = motion_sample_request |
        (fifo_request & merge);
    // The separate FIFO line goes quiet while merged
    assign fifo_line = fifo_request & ~merge;

    // Default routing puts motion on pin a and FIFO on pin b. Swap
    // only exchanges the two lines; pin settings stay with their pins.
    // Under merge plus swap the quiet FIFO line lands on pin a.
    assign req_a = swap ? fifo_line : merged_request;
    assign req_b = swap ? merged_request : fifo_line;

    // New request edges feed the status register
    assign rise = {req_b, req_a} & ~routed_prev_q;

    // Each pad gets its own driver so the two pins can never share
    // a mode bit by mistake
    // Pin a uses its own bits whatever request it carries
    pin_driver u_pin_a
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .request(req_a),
        .push_pull(pin_ctrl_q[`PIN_A_PUSH_PULL]),
        .active_high(pin_ctrl_q[`PIN_A_ACTIVE_HIGH]),
        .pin_out(irq_pin_a_out),
        .pin_oe(irq_pin_a_oe)
    );

    // Pin b likewise has its own bits
    pin_driver u_pin_b
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .request(req_b),
        .push_pull(pin_ctrl_q[`PIN_B_PUSH_PULL]),
        .active_high(pin_ctrl_q[`PIN_B_ACTIVE_HIGH]),
        .pin_out(irq_pin_b_out),
        .pin_oe(irq_pin_b_oe)
    );

    // Sticky status: a new edge beats a write-one clear
    always @*
    begin
        status_d = status_q;
        // Write-one clear from software
        if (wr_en && hit_status)
        begin
            status_d = status_q & ~pwdata[`IRQ_BITS-1:0];
        end
        // Clear and set in one cycle: the new edge is kept, so no
        // event is lost to a late clear from software
        status_d = status_d | rise;
    end

    // Control registers; reserved bits stay zero via the write masks.
    // Writes to the status and flag words touch no control register.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_ctrl_q <= `PIN_CTRL_RESET;
            swap_ctrl_q <= `REG_RESET;
            fifo_ctrl_q <= `REG_RESET;
            mask_q <= `SYNC_RESET;
        end
        else if (wr_en)
        begin
            // Pin drive and polarity
            if (hit_pin_ctrl)
            begin
                pin_ctrl_q <= pwdata[7:0] & `PIN_CTRL_WMASK;
            end
            // Swap bit only
            if (hit_swap_ctrl)
            begin
                swap_ctrl_q <= pwdata[7:0] & `SWAP_CTRL_WMASK;
            end
            // FIFO enables and merge
            if (hit_fifo_ctrl)
            begin
                fifo_ctrl_q <= pwdata[7:0] & `FIFO_CTRL_WMASK;
            end
            // Mask bits
            if (hit_mask)
            begin
                mask_q <= pwdata[`IRQ_BITS-1:0];
            end
        end
    end

    // Status and edge history advance only on enabled cycles
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_q <= `SYNC_RESET;
            routed_prev_q <= `SYNC_RESET;
        end
        else if (clk_en)
        begin
            status_q <= status_d;
            // History resets to zero, so a request high at reset shows
            // as an edge on the first enabled cycle
            routed_prev_q <= {req_b, req_a};
        end
    end

    // Reads sample in the setup cycle; a register that changes in the
    // same cycle shows its old value. With clk_en low in setup the
    // previous read data stands, so software must keep clk_en high.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (clk_en && rd_en)
        begin
            // Unmapped reads return zero
            if (hit_pin_ctrl)
            begin
                prdata <= {24'h000000, pin_ctrl_q};
            end
            else if (hit_swap_ctrl)
            begin
                prdata <= {24'h000000, swap_ctrl_q};
            end
            else if (hit_fifo_ctrl)
            begin
                prdata <= {24'h000000, fifo_ctrl_q};
            end
            else if (hit_status)
            begin
                prdata <= {30'h00000000, status_q};
            end
            else if (hit_mask)
            begin
                prdata <= {30'h00000000, mask_q};
            end
            else if (hit_flags)
            begin
                // Live view of routed requests and raw flags
                prdata <= {28'h0000000, req_b, req_a, fifo_flags};
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Level interrupt while any unmasked status bit stands;
    // combinational from flops, safe to sample anywhere in the cycle
    assign irq = |(status_q & mask_q);
    // Limitation: the mask gates only the summary line; the pins always
    // follow the routed requests, masked or not

endmodule

//--- irq_routing_defines.vh
`ifndef IRQ_ROUTING_DEFINES_VH
`define IRQ_ROUTING_DEFINES_VH

// Register indices; each takes one aligned word at four times its index
`define IDX_PIN_CTRL 8'h33
`define IDX_SWAP_CTRL 8'h31
`define IDX_FIFO_CTRL 8'h2D
`define IDX_IRQ_STATUS 8'h3C
`define IDX_IRQ_MASK 8'h3D
`define IDX_FIFO_FLAGS 8'h3E
// Index bits that survive in an 8-bit byte address
`define IDX_MSB 5

// Pin control fields
`define PIN_A_ACTIVE_HIGH 2
`define PIN_A_PUSH_PULL 3
`define PIN_B_ACTIVE_HIGH 6
`define PIN_B_PUSH_PULL 7
`define PIN_CTRL_WMASK 8'hCC
`define PIN_CTRL_RESET 8'h00

// Swap control fields
`define REQUEST_SWAP_BIT 4
`define SWAP_CTRL_WMASK 8'h10

// FIFO control fields
`define FIFO_FULL_EN_BIT 1
`define FIFO_THRESH_EN_BIT 2
`define MERGE_REQUESTS_BIT 3
`define FIFO_CTRL_WMASK 8'h0E

// Status / mask bits: 0 pin a edge, 1 pin b edge
`define IRQ_BITS 2
`define STAT_PIN_A 0
`define STAT_PIN_B 1

// FIFO flag inputs: bit 0 full, bit 1 threshold
`define FIFO_FLAG_FULL 0
`define FIFO_FLAG_THRESH 1

`define REG_RESET 8'h00
`define SYNC_RESET 2'h0

`endif

//--- pin_driver.v
`include "irq_routing_defines.vh"

// One interrupt pin: polarity and drive mode
module pin_driver
(
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // Control
    input wire request,
    input wire push_pull,
    input wire active_high,
    // Pad
    output reg pin_out,
    output reg pin_oe
);

    // Level that the pin shows for the current request, polarity last
    wire level_d;
    // Drive enable for this cycle
    wire oe_d;

    assign level_d = request ? active_high : ~active_high;
    // Open drain only ever pulls low; high means release
    assign oe_d = push_pull | ~level_d;

    // Registered pad outputs; reset gives released, low level
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            // Open drain drives only zero
            pin_out <= push_pull ? level_d : 1'b0;
            pin_oe <= oe_d;
        end
    end

endmodule

//--- irq_routing_asserts.sv
module irq_routing_asserts
(
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    // Requests and pins
    input wire motion_sample_request,
    input wire [1:0] fifo_flags,
    input wire irq_pin_a_out,
    input wire irq_pin_a_oe,
    input wire irq_pin_b_out,
    input wire irq_pin_b_oe,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of pin, swap and FIFO control, in that order
    logic [23:0] sh_q;
    wire wr = psel && penable && pwrite && clk_en;
    // Routing rebuilt from ports only, so a wrong body cannot hide
    wire fr = |(fifo_flags & sh_q[2:1]);
    wire l1 = motion_sample_request | (fr & sh_q[3]);
    wire l2 = fr & ~sh_q[3];
    wire la = (sh_q[12] ? l2 : l1) ^ ~sh_q[18];
    wire lb = (sh_q[12] ? l1 : l2) ^ ~sh_q[22];
    wire [1:0] pa = {sh_q[19] | ~la, sh_q[19] & la};
    wire [1:0] pb = {sh_q[23] | ~lb, sh_q[23] & lb};
    // Track register writes the same edge the slave takes them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sh_q <= 24'h000000;
        else if (wr && paddr == 8'hCC)
            sh_q[23:16] <= pwdata[7:0];
        else if (wr && paddr == 8'hC4)
            sh_q[15:8] <= pwdata[7:0];
        else if (wr && paddr == 8'hB4)
            sh_q[7:0] <= pwdata[7:0];
    end
    sequence apb_xfer;
        psel && !penable ##1 psel && penable;
    endsequence
    pin_a_route_a: assert property ($past(clk_en && presetn) |->
        {irq_pin_a_oe, irq_pin_a_out} == $past(pa))
        else $error("pin a does not follow its request");
    pin_b_route_a: assert property ($past(clk_en && presetn) |->
        {irq_pin_b_oe, irq_pin_b_out} == $past(pb))
        else $error("pin b does not follow its request");
    a_released_a: assert property (irq_pin_a_out |-> irq_pin_a_oe)
        else $error("pin a high while released");
    b_released_a: assert property (irq_pin_b_out |-> irq_pin_b_oe)
        else $error("pin b high while released");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    ready_a: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    bad_read_a: assert property (apb_xfer ##0 (!pwrite && pslverr)
        |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    ctrl_read_a: assert property (apb_xfer ##0 (!pwrite && paddr == 8'hCC)
        |-> prdata == {24'h000000, sh_q[23:16] & 8'hCC} && !pslverr)
        else $error("pin control readback wrong");
endmodule
bind interrupt_pin_routing irq_routing_asserts i_chk (.*);

//--- host_irq_model.sv
module host_irq_model
(
    // Pads from the device
    input wire a_out,
    input wire a_oe,
    input wire b_out,
    input wire b_oe,
    // Levels the host sees
    output wire a_lvl,
    output wire b_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // Board pull-ups lift a released line high
    assign a_lvl = a_oe ? a_out : 1'b1;
    assign b_lvl = b_oe ? b_out : 1'b1;
endmodule

//--- interrupt_pin_routing_bench.sv
module interrupt_pin_routing_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
    logic pwrite = 0, motion_sample_request = 0, fr, l1, l2, la, lb;
    logic [7:0] paddr = 8'h00, pc, sw, fc;
    logic [31:0] pwdata = 32'h0, rd;
    logic [1:0] fifo_flags = 2'h0;
    wire pready, pslverr, irq, a_out, a_oe, b_out, b_oe, a_lvl, b_lvl;
    wire [31:0] prdata;
    int n_mismatch = 0, comparisons = 0;
    always #10 pclk = ~pclk;
    interrupt_pin_routing i_dut (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .motion_sample_request(motion_sample_request),
        .fifo_flags(fifo_flags), .irq_pin_a_out(a_out), .irq_pin_a_oe(a_oe),
        .irq_pin_b_out(b_out), .irq_pin_b_oe(b_oe), .irq(irq));
    host_irq_model i_host (.a_out(a_out), .a_oe(a_oe), .b_out(b_out),
        .b_oe(b_oe), .a_lvl(a_lvl), .b_lvl(b_lvl));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("Compared %0d, mismatched %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // One APB transfer; an idle cycle first keeps strobes single-driven
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_mismatch++;
            conclude();
        end
        rd = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    // Reference routing, then polarity per physical pin
    task pins;
        fr = |(fifo_flags & fc[2:1]);
        l1 = motion_sample_request | (fr & fc[3]);
        l2 = fr & ~fc[3];
        la = (sw[4] ? l2 : l1) ^ ~pc[2];
        lb = (sw[4] ? l1 : l2) ^ ~pc[6];
        check({a_lvl, a_oe}, {la, pc[3] | ~la});
        check({b_lvl, b_oe}, {lb, pc[7] | ~lb});
    endtask
    initial
    begin
        void'($urandom(27899));
        repeat (10) @(posedge pclk);
        presetn <= 1;
        pc = 0;
        sw = 0;
        fc = 0;
        apb(0, 8'hCC, 0);
        check(rd, 32'h0);
        pins();
        $display("Reset test done");
        repeat (60)
        begin
            pc = $urandom;
            sw = $urandom;
            fc = $urandom;
            apb(1, 8'hCC, pc);
            apb(1, 8'hC4, sw);
            apb(1, 8'hB4, fc);
            apb(0, 8'hCC, 0);
            check(rd, pc & 8'hCC);
            motion_sample_request <= $urandom;
            fifo_flags <= $urandom;
            repeat (2) @(posedge pclk);
            pins();
        end
        $display("Routing test done");
        apb(0, 8'h00, 0);
        check(rd, 32'h0);
        $display("Unmapped test done");
        clk_en <= 0;
        apb(1, 8'hCC, 8'hFF);
        clk_en <= 1;
        apb(0, 8'hCC, 0);
        check(rd, pc & 8'hCC);
        $display("Enable test done");
        sw = 0;
        fc = 0;
        apb(1, 8'hC4, 0);
        motion_sample_request <= 0;
        apb(1, 8'hB4, 0);
        apb(1, 8'hF4, 1);
        apb(1, 8'hF0, 3);
        motion_sample_request <= 1;
        repeat (3) @(posedge pclk);
        check(irq, 1);
        apb(0, 8'hF0, 0);
        check(rd, 32'h1);
        apb(0, 8'hF8, 0);
        check(rd, {28'h0, 2'b01, fifo_flags});
        apb(1, 8'hF4, 0);
        @(posedge pclk);
        check(irq, 0);
        apb(1, 8'hF0, 1);
        apb(1, 8'hF4, 1);
        @(posedge pclk);
        check(irq, 0);
        $display("Interrupt test done");
        conclude();
    end
endmodule
